// ### ctc_top.sv
// Temperature compensation, inductor self-heating model and limit supervision, four channels
`timescale 1ns/1ps

module ctc_top
  import ctc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ctc_sample_t            smp,
  input  wire logic [1:0]             reg_page,
  input  wire logic [7:0]             reg_code,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_wdata,
  output logic      [15:0]            reg_rdata,
  output logic                        reg_ack,
  output logic                        reg_err,
  output ctc_chan_out_t [NCH-1:0]     chan_stat
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NCH != 4) begin : g_bad_nch
    $error("ctc_top serves exactly four channels");
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0]        cfg_r [NCH][NREG];
  logic signed [31:0] temp_r [NCH];
  logic signed [31:0] rise_r [NCH];
  ctc_chan_out_t [NCH-1:0] stat_r;
  logic [15:0]        rdata_r;
  logic               ack_r;
  logic               err_r;

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  ctc_dec_t    dec;
  logic        rise_hit;
  logic        wr_ok;
  logic        known;
  logic [15:0] rise_word;
  logic [15:0] rd_nxt;
  logic        err_nxt;

  assign dec      = ctc_decode(reg_code);
  assign rise_hit = (reg_code == CMD_RISE);
  assign known    = dec.hit | rise_hit;
  assign wr_ok    = reg_wr & dec.hit;
  // Rise reads back as Q8.8; it never leaves 0..50 so the integer part always fits
  assign rise_word = rise_r[reg_page][23:8];
  assign rd_nxt   = rise_hit ? rise_word : (dec.hit ? cfg_r[reg_page][dec.idx] : 16'h0000);
  assign err_nxt  = (reg_rd & ~known) | (reg_wr & ~dec.hit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        for (int k = 0; k < NREG; k++) begin
          cfg_r[c][k] <= RST_VAL[k];
        end
      end
    end else if (wr_ok) begin
      cfg_r[reg_page][dec.idx] <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_nxt : rdata_r;
      ack_r   <= reg_rd | reg_wr;
      err_r   <= err_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_ack   = ack_r;
  assign reg_err   = err_r;

  // ----------------------------------------------------------------------
  // Sample path: reading and self-heating of the sampled channel
  // ----------------------------------------------------------------------
  logic [15:0]        s_gain;
  logic signed [31:0] s_ofs;
  logic signed [31:0] s_theta;
  logic signed [31:0] s_rate;
  logic signed [31:0] s_rise;
  logic [47:0]        kel_prod;
  logic signed [31:0] t_ext;
  logic signed [31:0] t_sens;
  logic signed [31:0] power;
  logic signed [31:0] heat;
  logic signed [31:0] t_ind;
  logic signed [31:0] delta;
  logic signed [31:0] rise_nxt;
  logic               model_off;
  logic               model_raw;

  assign s_gain   = cfg_r[smp.chan][IX_GAIN];
  assign s_ofs    = ctc_l11_fx(cfg_r[smp.chan][IX_OFS]);
  assign s_theta  = ctc_l11_fx(cfg_r[smp.chan][IX_THETA]);
  assign s_rate   = ctc_l11_fx(cfg_r[smp.chan][IX_RATE]);
  assign s_rise   = rise_r[smp.chan];

  assign kel_prod = smp.t_kelvin * {32'h0000_0000, s_gain};
  // kelvin times gain minus 273.15 plus offset
  assign t_ext    = signed'(kel_prod[GAIN_FRAC +: 32]) - FX_KELVIN + s_ofs;
  // same sensor temperature feeds the model
  assign t_sens   = smp.sensor_ok ? t_ext : smp.die_temp;

  assign power    = ctc_mul(smp.iout, smp.vsense);
  assign heat     = ctc_mul(power, s_theta);
  assign t_ind    = s_rise + t_sens;
  assign delta    = ctc_mul(heat - t_ind, s_rate);
  assign model_off = (s_theta <= 0) | (s_rate <= 0);
  // rate of one or more skips the filter
  assign model_raw = (s_rate >= FX_ONE);
  assign rise_nxt = model_off ? 32'sh0000_0000 :
                    model_raw ? ctc_clamp(heat, 32'sh0000_0000, FX_RISE_MAX) :
                                ctc_clamp(s_rise + delta, 32'sh0000_0000, FX_RISE_MAX);

  // one update per channel sample, once per loop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        temp_r[c] <= 32'sh0000_0000;
        rise_r[c] <= 32'sh0000_0000;
      end
    end else if (smp.valid) begin
      temp_r[smp.chan] <= t_sens;
      rise_r[smp.chan] <= rise_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel correction, clamped thresholds and supervision
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic signed [31:0] res_w;
    logic signed [31:0] oc_w;
    logic signed [31:0] rc_w;
    logic signed [31:0] dt_w;
    logic signed [71:0] tc_prod;
    logic signed [31:0] tcorr_w;
    ctc_chan_out_t      nxt;

    assign res_w   = ctc_clamp(ctc_l11_fx(cfg_r[i][IX_SENSE]), FX_RES_MIN, FX_RES_MAX);
    assign oc_w    = ctc_l11_fx(cfg_r[i][IX_OC]);
    assign rc_w    = ctc_l11_fx(cfg_r[i][IX_RC]);
    assign dt_w    = temp_r[i] + rise_r[i] - FX_25C;
    // signed ppm coefficient
    // Reciprocal multiply avoids a divider; error is below one LSB of Q16.16
    assign tc_prod = 72'(signed'(cfg_r[i][IX_TC])) * 72'(dt_w) * 72'(PPM_RECIP);
    assign tcorr_w = ctc_clamp(FX_ONE + signed'(tc_prod[PPM_SHIFT +: 32]), FX_TC_MIN, FX_TC_MAX);

    assign nxt.temp      = temp_r[i];
    assign nxt.rise      = rise_r[i];
    assign nxt.tcorr     = tcorr_w;
    assign nxt.sense_res = res_w;
    assign nxt.oc_lim    = (oc_w < 0) ? 32'sh0000_0000 : oc_w;
    assign nxt.rc_lim    = (rc_w >= 0) ? FX_NEG_LSB : rc_w;
    assign nxt.ot_fault  = temp_r[i] > ctc_l11_fx(cfg_r[i][IX_OTF]);
    assign nxt.ot_warn   = temp_r[i] > ctc_l11_fx(cfg_r[i][IX_OTW]);
    assign nxt.ut_warn   = temp_r[i] < ctc_l11_fx(cfg_r[i][IX_UTW]);
    assign nxt.ut_fault  = temp_r[i] < ctc_l11_fx(cfg_r[i][IX_UTF]);

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stat_r[i] <= '0;
      end else begin
        stat_r[i] <= nxt;
      end
    end
  end

  assign chan_stat = stat_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic signed [31:0] rise0_w;
  logic signed [31:0] theta0_w;
  logic signed [31:0] rate0_w;
  logic signed [31:0] die_w;
  logic               rise_bad;
  logic signed [31:0] theta3_w;
  logic signed [31:0] rate3_w;
  logic signed [31:0] heat3_w;
  logic signed [31:0] raw3_w;
  logic signed [31:0] filt3_w;
  logic               filt3_on;

  // ----------------------------------------------------------------------
  // Channel 3 model rebuilt from the sample fields
  // ----------------------------------------------------------------------
  assign theta3_w = ctc_l11_fx(cfg_r[3][IX_THETA]);
  assign rate3_w  = ctc_l11_fx(cfg_r[3][IX_RATE]);
  assign heat3_w  = ctc_mul(ctc_mul(smp.iout, smp.vsense), theta3_w);
  assign raw3_w   = ctc_clamp(heat3_w, 32'sh0000_0000, FX_RISE_MAX);
  // Filter branch only; the other two branches have checks of their own
  assign filt3_on = (theta3_w > 0) && (rate3_w > 0) && (rate3_w < FX_ONE);
  assign filt3_w  = ctc_clamp(rise_r[3] + ctc_mul(heat3_w - rise_r[3] - t_sens, rate3_w),
                              32'sh0000_0000, FX_RISE_MAX);

  assign rise0_w  = rise_r[0];
  assign theta0_w = ctc_l11_fx(cfg_r[0][IX_THETA]);
  assign rate0_w  = ctc_l11_fx(cfg_r[0][IX_RATE]);
  assign die_w    = smp.die_temp;
  always_comb begin
    rise_bad = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      rise_bad = rise_bad | (rise_r[c] < 0) | (rise_r[c] > FX_RISE_MAX);
    end
  end

  sequence oc_write_s;
    reg_wr && reg_code == CMD_OC_FAULT && reg_page == 2'h0;
  endsequence

  sequence oc_read_s;
    reg_rd && !reg_wr && reg_code == CMD_OC_FAULT && reg_page == 2'h0;
  endsequence

  sequence ch0_sample_s;
    smp.valid && smp.chan == 2'h0;
  endsequence

  sequence ch3_sample_s;
    smp.valid && smp.chan == 2'h3;
  endsequence

  oc_clamp_a: assert property (chan_stat[0].oc_lim >= 0 || $past(rst))
    else $error("overcurrent threshold went negative");

  // Status is all zero for one cycle after reset, so that cycle is skipped
  rc_clamp_a: assert property ($past(rst) || chan_stat[1].rc_lim < 0)
    else $error("reverse current threshold not negative");

  raw_readback_a: assert property (oc_write_s ##1 !reg_wr ##1 oc_read_s |=>
                                   reg_rdata == $past(reg_wdata, 3))
    else $error("threshold readback differs from written word");

  rise_range_a: assert property (!rise_bad)
    else $error("rise left 0..50 degrees");

  rise_zero_a: assert property (ch0_sample_s ##0 (theta0_w <= 0 || rate0_w <= 0) |=>
                                rise0_w == 0)
    else $error("rise not forced to zero");

  rise3_zero_a: assert property (ch3_sample_s ##0 (theta3_w <= 0 || rate3_w <= 0) |=>
                                 rise_r[3] == 0)
    else $error("channel 3 rise not forced to zero");

  rise3_raw_a: assert property (ch3_sample_s ##0 (theta3_w > 0 && rate3_w >= FX_ONE) |=>
                                rise_r[3] == $past(raw3_w))
    else $error("unfiltered rise differs from theta times power");

  rise3_filt_a: assert property (ch3_sample_s ##0 filt3_on |=>
                                 rise_r[3] == $past(filt3_w))
    else $error("filtered rise step differs from the model");

  ot_reset_a: assert property ($past(rst) |-> cfg_r[0][IX_OTF] == RST_VAL[IX_OTF]
                               && cfg_r[0][IX_OTW] == RST_VAL[IX_OTW])
    else $error("overtemperature limits not at reset codes");

  ut_reset_a: assert property ($past(rst) |-> cfg_r[0][IX_UTF] == RST_VAL[IX_UTF]
                               && cfg_r[0][IX_UTW] == RST_VAL[IX_UTW])
    else $error("undertemperature limits not at reset codes");

  rise_hold_a: assert property (!(smp.valid && smp.chan == 2'h0) |=> $stable(rise0_w))
    else $error("channel 0 rise moved without its sample");

  die_fallback_a: assert property (ch0_sample_s ##0 !smp.sensor_ok |=>
                                   temp_r[0] == $past(die_w) ##2
                                   chan_stat[0].temp == $past(die_w, 3))
    else $error("die temperature not used for invalid sensor");

  tcorr_range_a: assert property ($past(rst) || (chan_stat[2].tcorr >= FX_TC_MIN
                                  && chan_stat[2].tcorr <= FX_TC_MAX))
    else $error("correction factor outside 0.25..4.0");

  rise_ro_a: assert property (reg_wr && reg_code == CMD_RISE |=> reg_err && reg_ack)
    else $error("write to read-only rise not refused");

  res_clamp_a: assert property ($past(rst) || (chan_stat[3].sense_res >= FX_RES_MIN
                                && chan_stat[3].sense_res <= FX_RES_MAX))
    else $error("sense resistance outside its range");

endmodule

// ### ctc_pkg.sv
// Register map, fixed-point constants, carrier types and helpers of the compensation block
package ctc_pkg;

  // ----------------------------------------------------------------------
  // Geometry and number format
  // ----------------------------------------------------------------------
  localparam int NCH       = 4;
  localparam int NREG      = 12;
  localparam int FX_FRAC   = 16;
  localparam int GAIN_FRAC = 14;
  localparam int PPM_SHIFT = 40;
  localparam int SENSE_LOOP_LEN = 4;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_SENSE_RES = 8'h38;
  localparam logic [7:0] CMD_OC_FAULT  = 8'h46;
  localparam logic [7:0] CMD_RC_FAULT  = 8'h4B;
  localparam logic [7:0] CMD_OT_FAULT  = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN   = 8'h51;
  localparam logic [7:0] CMD_UT_WARN   = 8'h52;
  localparam logic [7:0] CMD_UT_FAULT  = 8'h53;
  localparam logic [7:0] CMD_RISE      = 8'hB8;
  localparam logic [7:0] CMD_RATE      = 8'hB9;
  localparam logic [7:0] CMD_THETA     = 8'hBA;
  localparam logic [7:0] CMD_TEMPCO    = 8'hF6;
  localparam logic [7:0] CMD_DIODE_GN  = 8'hF8;
  localparam logic [7:0] CMD_DIODE_OFS = 8'hF9;

  // ----------------------------------------------------------------------
  // Storage slots and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] IX_SENSE = 4'h0;
  localparam logic [3:0] IX_OC    = 4'h1;
  localparam logic [3:0] IX_RC    = 4'h2;
  localparam logic [3:0] IX_OTF   = 4'h3;
  localparam logic [3:0] IX_OTW   = 4'h4;
  localparam logic [3:0] IX_UTW   = 4'h5;
  localparam logic [3:0] IX_UTF   = 4'h6;
  localparam logic [3:0] IX_RATE  = 4'h7;
  localparam logic [3:0] IX_THETA = 4'h8;
  localparam logic [3:0] IX_TC    = 4'h9;
  localparam logic [3:0] IX_GAIN  = 4'hA;
  localparam logic [3:0] IX_OFS   = 4'hB;
  localparam logic [15:0] RST_VAL [NREG] = '{16'hBA00, 16'hD280, 16'hB400, 16'hEA08,
                                             16'hE3C0, 16'h8000, 16'hCD80, 16'h8000,
                                             16'h8000, 16'h0000, 16'h4000, 16'h8000};

  // ----------------------------------------------------------------------
  // Fixed-point constants, Q16.16 except PPM_RECIP, which is 2^40 over one million
  // ----------------------------------------------------------------------
  localparam logic signed [31:0] FX_ONE    = 32'h0001_0000;
  localparam logic signed [31:0] FX_KELVIN = 32'h0111_2666;
  localparam logic signed [31:0] FX_25C    = 32'h0019_0000;
  localparam logic signed [31:0] FX_RISE_MAX = 32'h0032_0000;
  localparam logic signed [31:0] FX_TC_MIN = 32'h0000_4000;
  localparam logic signed [31:0] FX_TC_MAX = 32'h0004_0000;
  localparam logic signed [31:0] FX_RES_MIN = 32'h0000_0290;
  localparam logic signed [31:0] FX_RES_MAX = 32'h03E8_0000;
  localparam logic signed [31:0] FX_NEG_LSB = 32'hFFFF_FFFF;
  localparam logic signed [31:0] PPM_RECIP = 32'h0010_C6F8;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic               valid;
    logic [1:0]         chan;
    logic               sensor_ok;
    logic [31:0]        t_kelvin;
    logic signed [31:0] die_temp;
    logic signed [31:0] iout;
    logic signed [31:0] vsense;
  } ctc_sample_t;

  typedef struct packed {
    logic signed [31:0] temp;
    logic signed [31:0] rise;
    logic signed [31:0] tcorr;
    logic signed [31:0] sense_res;
    logic signed [31:0] oc_lim;
    logic signed [31:0] rc_lim;
    logic               ot_fault;
    logic               ot_warn;
    logic               ut_warn;
    logic               ut_fault;
  } ctc_chan_out_t;

  typedef struct packed {
    logic       hit;
    logic [3:0] idx;
  } ctc_dec_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic ctc_dec_t ctc_decode(input logic [7:0] code);
    ctc_dec_t d;
    d.hit = 1'b1;
    d.idx = IX_SENSE;
    unique case (code)
      CMD_SENSE_RES: d.idx = IX_SENSE;
      CMD_OC_FAULT:  d.idx = IX_OC;
      CMD_RC_FAULT:  d.idx = IX_RC;
      CMD_OT_FAULT:  d.idx = IX_OTF;
      CMD_OT_WARN:   d.idx = IX_OTW;
      CMD_UT_WARN:   d.idx = IX_UTW;
      CMD_UT_FAULT:  d.idx = IX_UTF;
      CMD_RATE:      d.idx = IX_RATE;
      CMD_THETA:     d.idx = IX_THETA;
      CMD_TEMPCO:    d.idx = IX_TC;
      CMD_DIODE_GN:  d.idx = IX_GAIN;
      CMD_DIODE_OFS: d.idx = IX_OFS;
      default:       d.hit = 1'b0;
    endcase
    return d;
  endfunction

  // Exponent plus 16 is the exponent with its sign bit flipped
  function automatic logic signed [31:0] ctc_l11_fx(input logic [15:0] code);
    logic [4:0]         sh;
    logic signed [63:0] m;
    sh = {~code[15], code[14:11]};
    m  = 64'(signed'(code[10:0]));
    m  = m <<< sh;
    return m[31:0];
  endfunction

  function automatic logic signed [31:0] ctc_mul(input logic signed [31:0] a,
                                                 input logic signed [31:0] b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    return p[47:16];
  endfunction

  function automatic logic signed [31:0] ctc_clamp(input logic signed [31:0] v,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

// ### ctc_adc_model.sv
// ADC sequencer stand-in that hands the compensation block one sample at a time
`timescale 1ns/1ps

module ctc_adc_model
  import ctc_pkg::*;
(
  input  wire logic  clk,
  output ctc_sample_t smp
);
  initial smp = '0;

  // ----------------------------------------------------------------------
  // Sample hand-off
  // ----------------------------------------------------------------------
  // one sample per slot
  // Fields go to their inverse after the pulse so stale data never looks valid
  task automatic send(input logic [1:0] ch, input logic ok, input logic [31:0] tk,
                      input logic [31:0] die, input logic [31:0] io, input logic [31:0] vs);
    ctc_sample_t s;
    s = '{1'b1, ch, ok, tk, die, io, vs};
    @(posedge clk);
    smp <= s;
    @(posedge clk);
    smp <= ~s;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// ### tb_ctc_top.sv
// Self-checking bench for the four-channel temperature compensation block
`timescale 1ns/1ps

module tb_ctc_top
  import ctc_pkg::*;
();
  logic                    clk       = 1'b0;
  logic                    rst       = 1'b1;
  ctc_sample_t             smp;
  logic [1:0]              reg_page  = 2'h0;
  logic [7:0]              reg_code  = 8'h00;
  logic                    reg_wr    = 1'b0;
  logic                    reg_rd    = 1'b0;
  logic [15:0]             reg_wdata = 16'h0000;
  logic [15:0]             reg_rdata;
  logic                    reg_ack;
  logic                    reg_err;
  ctc_chan_out_t [NCH-1:0] chan_stat;
  int                      miscompares     = 0;
  int                      samples_checked = 0;
  int                      cycles          = 0;
  logic [7:0]              rcode [12] = '{8'h4F, 8'h51, 8'h52, 8'h53, 8'hB9, 8'hBA,
                                          8'hF8, 8'hF9, 8'hF6, 8'h46, 8'h4B, 8'h38};
  logic [15:0]             rval  [12] = '{16'hEA08, 16'hE3C0, 16'h8000, 16'hCD80,
                                          16'h8000, 16'h8000, 16'h4000, 16'h8000,
                                          16'h0000, 16'hD280, 16'hB400, 16'hBA00};
  int                      tt    [5]  = '{70, 65, 30, -5, -10};
  logic [3:0]              ff    [5]  = '{4'hC, 4'h4, 4'h0, 4'h2, 4'h3};

  always #5 clk = ~clk;

  ctc_top u_ctc_top (.clk(clk), .rst(rst), .smp(smp), .reg_page(reg_page),
                     .reg_code(reg_code), .reg_wr(reg_wr), .reg_rd(reg_rd),
                     .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
                     .reg_err(reg_err), .chan_stat(chan_stat));
  ctc_adc_model u_ctc_adc_model (.clk(clk), .smp(smp));

  // ----------------------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_fx(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe is a one-cycle pulse; answer is looked at in the cycle after it
  task automatic reg_op(input logic w, input logic [1:0] pg, input logic [7:0] code,
                        input logic [15:0] wd, input logic e);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_page <= pg;
    reg_code <= code;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk_flag({2'b00, reg_ack, reg_err}, {3'b001, e});
  endtask

  task automatic wr(input logic [1:0] pg, input logic [7:0] code, input logic [15:0] wd,
                    input logic e);
    reg_op(1'b1, pg, code, wd, e);
  endtask

  task automatic rd(input logic [1:0] pg, input logic [7:0] code, input logic [15:0] exp,
                    input logic e);
    reg_op(1'b0, pg, code, 16'h0000, e);
    chk_word(reg_rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] fx(input int d);
    return 32'(d * 65536);
  endfunction

  // Hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle();
    for (int i = 0; i < 12; i++) begin
      rd(2'h1, rcode[i], rval[i], 1'b0);
    end
    chk_fx(chan_stat[0].rise, 32'h0);
    chk_fx(chan_stat[0].oc_lim, fx(10));
    chk_fx(chan_stat[0].rc_lim, fx(-1));
    chk_fx(chan_stat[0].sense_res, fx(1));
    // Write then read with one idle cycle between, so the readback assertion sees it too
    wr(2'h0, 8'h46, 16'hB400, 1'b0);
    rd(2'h0, 8'h46, 16'hB400, 1'b0);
    wr(2'h0, 8'h4B, 16'hBA00, 1'b0);
    rd(2'h0, 8'h4B, 16'hBA00, 1'b0);
    wr(2'h0, 8'h38, 16'h8001, 1'b0);
    settle();
    chk_fx(chan_stat[0].oc_lim, 32'h0);
    chk_fx(chan_stat[0].rc_lim, 32'hFFFF_FFFF);
    chk_fx(chan_stat[0].sense_res, FX_RES_MIN);
    wr(2'h0, 8'h38, 16'h0BE8, 1'b0);
    settle();
    chk_fx(chan_stat[0].sense_res, FX_RES_MAX);
    rd(2'h0, 8'h38, 16'h0BE8, 1'b0);
    wr(2'h0, 8'h00, 16'h1234, 1'b1);
    rd(2'h0, 8'h00, 16'h0000, 1'b1);
    // Doubled diode gain with five degrees of offset
    wr(2'h1, 8'hF8, 16'h8000, 1'b0);
    wr(2'h1, 8'hF9, 16'hCA80, 1'b0);
    u_ctc_adc_model.send(2'h1, 1'b1, fx(300), fx(1), 32'h0, 32'h0);
    chk_fx(chan_stat[1].temp, 32'h025D_0000 - FX_KELVIN);
    // Invalid diode: die temperature wins over gain and offset
    wr(2'h2, 8'hF8, 16'h8000, 1'b0);
    wr(2'h2, 8'hF9, 16'hCA80, 1'b0);
    for (int i = 0; i < 5; i++) begin
      u_ctc_adc_model.send(2'h2, 1'b0, fx(300), fx(tt[i]), 32'h0, 32'h0);
      chk_fx(chan_stat[2].temp, fx(tt[i]));
      chk_flag({chan_stat[2].ot_fault, chan_stat[2].ot_warn, chan_stat[2].ut_warn,
                chan_stat[2].ut_fault}, ff[i]);
    end
    chk_fx(chan_stat[1].temp, 32'h025D_0000 - FX_KELVIN);
    // Correction factor saturates at both ends; untouched channel stays at one
    wr(2'h2, 8'hF6, 16'h7FFF, 1'b0);
    u_ctc_adc_model.send(2'h2, 1'b0, 32'h0, fx(200), 32'h0, 32'h0);
    chk_fx(chan_stat[2].tcorr, FX_TC_MAX);
    wr(2'h2, 8'hF6, 16'h8000, 1'b0);
    u_ctc_adc_model.send(2'h2, 1'b0, 32'h0, fx(200), 32'h0, 32'h0);
    chk_fx(chan_stat[2].tcorr, FX_TC_MIN);
    u_ctc_adc_model.send(2'h0, 1'b0, 32'h0, fx(200), 32'h0, 32'h0);
    chk_fx(chan_stat[0].tcorr, FX_ONE);
    // Self-heating on channel 3, power 10 W then 50 W at theta 2
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), fx(5), fx(2));
    chk_fx(chan_stat[3].rise, 32'h0);
    wr(2'h3, 8'hBA, 16'hC200, 1'b0);
    wr(2'h3, 8'hB9, 16'hBA00, 1'b0);
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), fx(5), fx(2));
    chk_fx(chan_stat[3].rise, fx(20));
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), fx(10), fx(5));
    chk_fx(chan_stat[3].rise, fx(50));
    rd(2'h3, 8'hB8, 16'h3200, 1'b0);
    wr(2'h3, 8'hB8, 16'h0000, 1'b1);
    rd(2'h3, 8'hB8, 16'h3200, 1'b0);
    rd(2'h0, 8'hB8, 16'h0000, 1'b0);
    rd(2'h3, 8'hBA, 16'hC200, 1'b0);
    // Filtered decay at rate one half with no power
    wr(2'h3, 8'hB9, 16'hF801, 1'b0);
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), 32'h0, 32'h0);
    chk_fx(chan_stat[3].rise, fx(25));
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), 32'h0, 32'h0);
    chk_fx(chan_stat[3].rise, 32'h000C_8000);
    // Hot die drives the step below zero, which only holds if die is the sensor
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(100), 32'h0, 32'h0);
    chk_fx(chan_stat[3].rise, 32'h0);
    wr(2'h3, 8'hB9, 16'hBA00, 1'b0);
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), fx(5), fx(2));
    chk_fx(chan_stat[3].rise, fx(20));
    wr(2'h3, 8'hBA, 16'hB400, 1'b0);
    u_ctc_adc_model.send(2'h3, 1'b0, 32'h0, fx(0), fx(5), fx(2));
    chk_fx(chan_stat[3].rise, 32'h0);
    test_done();
  end
endmodule
